// *** common/eapc_regs.vh ***
// register map, field layout, reset values and encodings of the external and pin-change irq block
`ifndef EAPC_REGS_VH
`define EAPC_REGS_VH

// register indices on the 4-bit address port
`define EAPC_ADDR_SENSE    4'h0
`define EAPC_ADDR_EXTMASK  4'h1
`define EAPC_ADDR_EXTFLAG  4'h2
`define EAPC_ADDR_PCENABLE 4'h3
`define EAPC_ADDR_PCFLAG   4'h4
`define EAPC_ADDR_PCMASK0  4'h5
`define EAPC_ADDR_PCMASK1  4'h6
`define EAPC_ADDR_PCMASK2  4'h7
`define EAPC_ADDR_PCMASK3  4'h8

// reset values
`define EAPC_RST_BYTE      8'h00
`define EAPC_RST_NIBBLE    4'h0

// sense field encodings
`define EAPC_SENSE_LOW     2'h0
`define EAPC_SENSE_CHANGE  2'h1
`define EAPC_SENSE_FALL    2'h2
`define EAPC_SENSE_RISE    2'h3

// field positions and widths
`define EAPC_SENSE_W       2
`define EAPC_EXT_N         4
`define EAPC_GRP_N         4
`define EAPC_PC_N          27
`define EAPC_G1_W          7
`define EAPC_G3_W          3
`define EAPC_G0_LSB        0
`define EAPC_G1_LSB        8
`define EAPC_G2_LSB        16
`define EAPC_G3_LSB        24

`endif

// *** design/eapc_sync.v ***
// two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module eapc_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst,
  // pins in, synchronised levels out
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // first stage feeds only the second stage
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q   <= {WIDTH{1'b1}};
      stable_q <= {WIDTH{1'b1}};
    end else begin
      meta_q   <= asyncIn;
      stable_q <= meta_q;
    end
  end

  assign syncOut = stable_q;
endmodule // eapc_sync

// *** design/eapc_irq.v ***
// external and pin-change interrupt controller: sense logic, flags, masks and register port
//
// Behaviour
// [RQ1] sense 00 low level, 01 any change, 10 falling edge, 11 rising edge
// [RQ2] sense register: int3 bits 7:6, int2 5:4, int1 3:2, int0 1:0
// [RQ3] external request reaches cpu only with global flag and own enable set
// [RQ4] edges found by comparing successive samples; pulses over one clock caught
// [RQ5] source holds level low until the current instruction completes
// [RQ6] enabled low-level interrupt requests continuously while the pin stays low
// [RQ7] software disables an interrupt before changing its sense field
// [RQ8] external mask bits 3..0 enable external interrupts 3..0
// [RQ9] pin activity triggers even when the pin is driven as output
// [RQ10] bits 7..4 of mask, flag, group enable, group flag read zero
// [RQ11] detected edge sets external flag; request if global and enable set
// [RQ12] flags clear on vector acknowledge or on a written one
// [RQ13] external flag held clear while in low-level mode
// [RQ14] group enables 3..0 cover pins 26..24, 23..16, 15..8, 7..0
// [RQ15] change on any enabled group pin raises that group's own request
// [RQ16] each group pin has its own mask bit; masked pins ignored (code: pin 15 has no mask bit and is always masked)
// [RQ17] enabled pin change sets group flag; request if global and enable set
// [RQ18] group 3 mask bits 7..3 read zero
// [RQ19] pins sampled before edge detection, independent of cpu timing
// [RQ20] group 3 mask bits 2..0 enable pins 26..24
// [RQ21] pin changes also flagged asynchronously as a wake request
// [RQ22] low level wakes asynchronously; edges need the running clock
// [RQ23] one request line per vector, acknowledge pulse clears its flag
// [RQ24] pins pass two flip-flops before edge comparison
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "eapc_regs.vh"
module eapc_irq (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // register port
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [7:0]  regRdData,
  // cpu side
  input  wire        globalIrqEn,
  output wire [7:0]  irqReq,
  input  wire [7:0]  irqAck,
  output wire        wakeReq,
  // pins
  input  wire [3:0]  extIrqPin,
  input  wire [26:0] pcInputPin
);
  // register state
  reg  [7:0]  senseCtrl_q;
  reg  [3:0]  extMask_q;
  reg  [3:0]  extFlag_q;
  reg  [3:0]  extFlag_d;
  reg  [3:0]  pcGroupEn_q;
  reg  [3:0]  pcGroupFlag_q;
  reg  [3:0]  pcGroupFlag_d;
  reg  [7:0]  pcMaskG0_q;
  reg  [6:0]  pcMaskG1_q;
  reg  [7:0]  pcMaskG2_q;
  reg  [2:0]  pcMaskG3_q;
  reg  [7:0]  rdMux;

  // sampled pins and previous sample
  wire [30:0] syncPins;
  wire [3:0]  extNow;
  wire [26:0] pcNow;
  reg  [3:0]  extPrev_q;
  reg  [26:0] pcPrev_q;
  reg         primed_q;

  // per-channel events
  wire [3:0]  extEvent;
  wire [3:0]  extLevelMode;
  wire [3:0]  extLevelReq;
  wire [3:0]  extReq;
  wire [3:0]  pcReq;
  wire [26:0] pcMaskAll;
  wire [26:0] pcChange;
  wire [3:0]  pcEvent;
  wire [3:0]  extW1c;
  wire [3:0]  pcW1c;
  wire        wrSense;
  wire        wrExtMask;
  wire        wrPcEn;

  // pins never see the direction of the port, so driven outputs trigger too
  eapc_sync #(
    .WIDTH (31)
  ) u_sync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn ({pcInputPin, extIrqPin}),
    .syncOut (syncPins)
  ); // [RQ24] [RQ9] [RQ19]

  assign extNow = syncPins[3:0];
  assign pcNow  = syncPins[30:4];

  // previous sample for edge comparison; primed gates only the first cycle, so a pin low at reset release still gives a falling edge
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      extPrev_q <= 4'hf;
      pcPrev_q  <= {27{1'b1}};
      primed_q  <= 1'b0;
    end else begin
      extPrev_q <= extNow; // [RQ4]
      pcPrev_q  <= pcNow;
      primed_q  <= 1'b1;
    end
  end

  // register write decode
  assign wrSense   = regWrEn && (regAddr == `EAPC_ADDR_SENSE);
  assign wrExtMask = regWrEn && (regAddr == `EAPC_ADDR_EXTMASK);
  assign wrPcEn    = regWrEn && (regAddr == `EAPC_ADDR_PCENABLE);
  assign extW1c    = (regWrEn && (regAddr == `EAPC_ADDR_EXTFLAG)) ? regWrData[3:0] : 4'h0; // [RQ12]
  assign pcW1c     = (regWrEn && (regAddr == `EAPC_ADDR_PCFLAG)) ? regWrData[3:0] : 4'h0; // [RQ12]

  // external channels
  genvar n;
  generate
    for (n = 0; n < `EAPC_EXT_N; n = n + 1) begin : g_ext
      wire [1:0] sense;
      wire       rise;
      wire       fall;
      // field n sits at bits 2n+1:2n
      assign sense = senseCtrl_q[2*n+1:2*n]; // [RQ2]
      assign rise  = primed_q && extNow[n] && !extPrev_q[n];
      assign fall  = primed_q && !extNow[n] && extPrev_q[n];
      assign extLevelMode[n] = (sense == `EAPC_SENSE_LOW);
      // decode of the trigger; a sense change while enabled may fire once
      assign extEvent[n] = (sense == `EAPC_SENSE_CHANGE) ? (rise | fall) :
                           (sense == `EAPC_SENSE_FALL)   ? fall :
                           (sense == `EAPC_SENSE_RISE)   ? rise : 1'b0; // [RQ1] [RQ4] [RQ7]
      // level request follows the pin with no flag behind it
      assign extLevelReq[n] = extLevelMode[n] && !extNow[n]; // [RQ6] [RQ5]
      assign extReq[n] = globalIrqEn && extMask_q[n] &&
                         (extLevelMode[n] ? extLevelReq[n] : extFlag_q[n]); // [RQ3] [RQ8] [RQ11]

      always @* begin
        if (extLevelMode[n]) begin
          extFlag_d[n] = 1'b0; // [RQ13]
        end else if (extEvent[n]) begin
          extFlag_d[n] = 1'b1; // [RQ11]
        end else if (irqAck[n] || extW1c[n]) begin
          extFlag_d[n] = 1'b0; // [RQ12] [RQ23]
        end else begin
          extFlag_d[n] = extFlag_q[n];
        end
      end
    end
  endgenerate

  // pin-change groups
  // pin 15 has no mask bit, so it sits as a zero between group 1 and group 2
  assign pcMaskAll = {pcMaskG3_q, pcMaskG2_q, 1'b0, pcMaskG1_q, pcMaskG0_q}; // [RQ16] [RQ20]
  assign pcChange  = primed_q ? ((pcNow ^ pcPrev_q) & pcMaskAll) : {27{1'b0}}; // [RQ16]

  assign pcEvent[0] = |pcChange[`EAPC_G1_LSB-1:`EAPC_G0_LSB]; // [RQ14] [RQ15]
  assign pcEvent[1] = |pcChange[`EAPC_G2_LSB-1:`EAPC_G1_LSB];
  assign pcEvent[2] = |pcChange[`EAPC_G3_LSB-1:`EAPC_G2_LSB];
  assign pcEvent[3] = |pcChange[`EAPC_PC_N-1:`EAPC_G3_LSB];

  generate
    for (n = 0; n < `EAPC_GRP_N; n = n + 1) begin : g_grp
      // new change wins over a clear in the same cycle
      always @* begin
        if (pcEvent[n]) begin
          pcGroupFlag_d[n] = 1'b1; // [RQ17]
        end else if (irqAck[`EAPC_EXT_N+n] || pcW1c[n]) begin
          pcGroupFlag_d[n] = 1'b0; // [RQ12] [RQ23]
        end else begin
          pcGroupFlag_d[n] = pcGroupFlag_q[n];
        end
      end
      assign pcReq[n] = globalIrqEn && pcGroupEn_q[n] && pcGroupFlag_q[n]; // [RQ14] [RQ17]
    end
  endgenerate

  // one line per vector: ext 0..3 then groups 0..3
  assign irqReq = {pcReq, extReq}; // [RQ23] [RQ15]

  // wake path looks at raw pins so it works with the clock stopped;
  // it is glitch-prone by nature and only meant to start the clocks
  assign wakeReq = |(extMask_q & extLevelMode & ~extIrqPin) |
                   |(pcMaskAll & (pcInputPin ^ pcPrev_q) &
                     {{3{pcGroupEn_q[3]}}, {8{pcGroupEn_q[2]}},
                      {8{pcGroupEn_q[1]}}, {8{pcGroupEn_q[0]}}}); // [RQ21] [RQ22]

  // registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      senseCtrl_q   <= `EAPC_RST_BYTE;
      extMask_q     <= `EAPC_RST_NIBBLE;
      extFlag_q     <= `EAPC_RST_NIBBLE;
      pcGroupEn_q   <= `EAPC_RST_NIBBLE;
      pcGroupFlag_q <= `EAPC_RST_NIBBLE;
      pcMaskG0_q    <= `EAPC_RST_BYTE;
      pcMaskG1_q    <= 7'h00;
      pcMaskG2_q    <= `EAPC_RST_BYTE;
      pcMaskG3_q    <= 3'h0;
    end else begin
      extFlag_q     <= extFlag_d;
      pcGroupFlag_q <= pcGroupFlag_d;
      if (wrSense) begin
        senseCtrl_q <= regWrData; // [RQ2]
      end
      if (wrExtMask) begin
        extMask_q <= regWrData[3:0]; // [RQ8]
      end
      if (wrPcEn) begin
        pcGroupEn_q <= regWrData[3:0]; // [RQ14]
      end
      if (regWrEn && (regAddr == `EAPC_ADDR_PCMASK0)) begin
        pcMaskG0_q <= regWrData;
      end
      if (regWrEn && (regAddr == `EAPC_ADDR_PCMASK1)) begin
        pcMaskG1_q <= regWrData[6:0];
      end
      if (regWrEn && (regAddr == `EAPC_ADDR_PCMASK2)) begin
        pcMaskG2_q <= regWrData;
      end
      if (regWrEn && (regAddr == `EAPC_ADDR_PCMASK3)) begin
        pcMaskG3_q <= regWrData[2:0]; // [RQ20]
      end
    end
  end

  // read mux; unused upper bits and unmapped addresses read zero
  always @* begin
    case (regAddr)
      `EAPC_ADDR_SENSE:    rdMux = senseCtrl_q;
      `EAPC_ADDR_EXTMASK:  rdMux = {4'h0, extMask_q}; // [RQ10]
      `EAPC_ADDR_EXTFLAG:  rdMux = {4'h0, extFlag_q}; // [RQ10]
      `EAPC_ADDR_PCENABLE: rdMux = {4'h0, pcGroupEn_q}; // [RQ10]
      `EAPC_ADDR_PCFLAG:   rdMux = {4'h0, pcGroupFlag_q}; // [RQ10]
      `EAPC_ADDR_PCMASK0:  rdMux = pcMaskG0_q;
      `EAPC_ADDR_PCMASK1:  rdMux = {1'b0, pcMaskG1_q};
      `EAPC_ADDR_PCMASK2:  rdMux = pcMaskG2_q;
      `EAPC_ADDR_PCMASK3:  rdMux = {5'h00, pcMaskG3_q}; // [RQ18]
      default:             rdMux = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule // eapc_irq

// *** tb/eapc_irq_monitor.sv ***
// assertion checker on the irq block ports
`timescale 1ns/1ps
module eapc_irq_monitor (
  // clock
  input logic        clock,
  input logic        rst,
  // registers
  input logic [3:0]  regAddr,
  input logic [7:0]  regWrData,
  input logic        regWrEn,
  input logic        regRdEn,
  input logic [7:0]  regRdData,
  // cpu and pins
  input logic        globalIrqEn,
  input logic [7:0]  irqReq,
  input logic [7:0]  irqAck,
  input logic [3:0]  extIrqPin,
  input logic [26:0] pcInputPin
);
  // quiet cycles of all pins; flags settle three cycles after a change
  logic [2:0]  quiet_q;
  logic [30:0] pins_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      quiet_q <= 3'h0;
      pins_q  <= 31'h0;
    end else begin
      pins_q  <= {extIrqPin, pcInputPin};
      quiet_q <= (pins_q != {extIrqPin, pcInputPin}) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
    end
  end
  property p_gate; !globalIrqEn |-> irqReq == 8'h00; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_upper; $past(regRdEn) && $past(regAddr) inside {[4'h1:4'h4]} |-> regRdData[7:4] == 4'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_g3; $past(regRdEn) && $past(regAddr) == 4'h8 |-> regRdData[7:3] == 5'h00; endproperty
  a_g3: assert property (p_g3) else $error("group3 mask bits");
  property p_sense; regWrEn && regAddr == 4'h0 ##1 regRdEn && regAddr == 4'h0 |=> regRdData == $past(regWrData, 2);
  endproperty
  a_sense: assert property (p_sense) else $error("sense readback");
  property p_mask; regWrEn && regAddr == 4'h1 ##1 regRdEn && regAddr == 4'h1
    |=> regRdData == ($past(regWrData, 2) & 8'h0f); endproperty
  a_mask: assert property (p_mask) else $error("mask readback");
  property p_ack; quiet_q > 3'h4 && (irqAck & irqReq & 8'hf0) != 8'h00 |=> (irqReq & $past(irqAck)) == 8'h00;
  endproperty
  a_ack: assert property (p_ack) else $error("ack kept request");
  property p_pcq; quiet_q > 3'h4 && !regWrEn ##1 $stable(globalIrqEn) |-> (irqReq & ~$past(irqReq) & 8'hf0) == 8'h00;
  endproperty
  a_pcq: assert property (p_pcq) else $error("group request without change");
  property p_extq; quiet_q > 3'h4 && !regWrEn ##1 $stable(globalIrqEn) |-> (irqReq & ~$past(irqReq) & 8'h0f) == 8'h00;
  endproperty
  a_extq: assert property (p_extq) else $error("ext request without event");
  c_ext: cover property (irqReq[0]);
  c_ack: cover property (irqAck[4] && irqReq[4]);
  c_grp3: cover property (irqReq[7]);
endmodule // eapc_irq_monitor

// *** tb/eapc_cpu_model.sv ***
// cpu side model: acknowledges pending requests after a set wait
`timescale 1ns/1ps
module eapc_cpu_model (
  // clock
  input  logic       clock,
  input  logic       rst,
  // bench control
  input  logic       ackOn,
  input  logic [3:0] ackWait,
  // vectors
  input  logic [7:0] irqReq,
  output logic [7:0] irqAck
);
  logic [3:0] wait_q;
  // lowest vector first, one at a time, like a priority encoder
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      irqAck <= 8'h00;
    end else if (irqAck != 8'h00 || !ackOn || irqReq == 8'h00) begin
      wait_q <= 4'h0;
      irqAck <= 8'h00;
    end else if (wait_q < ackWait) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      irqAck <= irqReq & (~irqReq + 8'h01);
    end
  end
endmodule // eapc_cpu_model

// *** tb/tb_eapc_irq.sv ***
// testbench of the irq block
`timescale 1ns/1ps
`include "eapc_regs.vh"
module tb_eapc_irq;
  logic        clock, rst, regWrEn, regRdEn, globalIrqEn, ackOn, wakeReq;
  logic [3:0]  regAddr, extIrqPin, ackWait;
  logic [7:0]  regWrData, regRdData, irqReq, irqAck, rdVal;
  logic [26:0] pcInputPin;
  int          err_count, n_compared;
  eapc_irq i_eapc_irq (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .globalIrqEn(globalIrqEn), .irqReq(irqReq), .irqAck(irqAck),
    .wakeReq(wakeReq), .extIrqPin(extIrqPin), .pcInputPin(pcInputPin));
  eapc_cpu_model i_eapc_cpu_model (.clock(clock), .rst(rst), .ackOn(ackOn), .ackWait(ackWait), .irqReq(irqReq),
    .irqAck(irqAck));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic stop_test();
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] e);
    n_compared++;
    if (seen !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, e, seen);
    end
  endtask
  // the write strobe stays up until the next task lowers it; rc lowers its own read strobe after one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regRdEn <= 1'b0;
    regWrEn <= 1'b1;
    @(posedge clock);
  endtask
  task automatic cyc(input int n);
    regWrEn <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task automatic rc(input string s, input logic [3:0] a, input logic [7:0] e);
    regAddr <= a;
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    @(negedge clock);
    chk(s, regRdData, e);
    @(posedge clock);
  endtask
  task automatic see(input string s, input logic [7:0] e);
    regWrEn <= 1'b0;
    @(negedge clock);
    chk(s, irqReq, e);
    @(posedge clock);
  endtask
  task automatic t_regs();
    logic [7:0] ev [9] = '{8'hff, 8'h0f, 8'h00, 8'h0f, 8'h00, 8'hff, 8'h7f, 8'hff, 8'h07};
    for (int a = 0; a < 10; a++) begin
      rc("reset value", a[3:0], 8'h00);
      wr(a[3:0], 8'hff);
      rc("written", a[3:0], (a < 9) ? ev[a] : 8'h00);
      wr(a[3:0], 8'h00);
    end
  endtask
  task automatic t_ext();
    globalIrqEn <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      wr(`EAPC_ADDR_EXTMASK, 8'h00);
      wr(`EAPC_ADDR_SENSE, 8'(n << (2 * n)));
      wr(`EAPC_ADDR_EXTMASK, 8'(1 << n));
      extIrqPin <= ~4'(1 << n);
      cyc(4);
      see("low or fall", (n == 3) ? 8'h00 : 8'(1 << n));
      #1 chk("wake", {7'h00, wakeReq}, (n == 0) ? 8'h01 : 8'h00);
      extIrqPin <= 4'hf;
      cyc(4);
      see("after pulse", (n == 0) ? 8'h00 : 8'(1 << n));
      globalIrqEn <= 1'b0;
      see("gated", 8'h00);
      globalIrqEn <= 1'b1;
      rc("ext flag", `EAPC_ADDR_EXTFLAG, (n == 0) ? 8'h00 : 8'(1 << n));
      wr(`EAPC_ADDR_EXTFLAG, 8'(1 << n));
      rc("ext flag clear", `EAPC_ADDR_EXTFLAG, 8'h00);
    end
    wr(`EAPC_ADDR_EXTMASK, 8'h00);
  endtask
  task automatic t_pc();
    wr(`EAPC_ADDR_PCENABLE, 8'h0f);
    for (int g = 0; g < 4; g++) begin
      wr(4'(`EAPC_ADDR_PCMASK0 + g), 8'h02);
      pcInputPin <= pcInputPin ^ (27'h1 << (8 * g));
      cyc(4);
      see("masked pin", 8'h00);
      pcInputPin <= pcInputPin ^ (27'h2 << (8 * g));
      cyc(4);
      see("group request", 8'(8'h10 << g));
      rc("group flag", `EAPC_ADDR_PCFLAG, 8'(1 << g));
      ackWait <= 4'(3 * g);
      ackOn <= 1'b1;
      for (int t = 0; t < 16 && irqReq !== 8'h00; t++) @(posedge clock);
      if (irqReq !== 8'h00) begin
        err_count++;
        stop_test();
      end
      ackOn <= 1'b0;
      see("acked", 8'h00);
      rc("group flag clear", `EAPC_ADDR_PCFLAG, 8'h00);
    end
  endtask
  initial begin
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    globalIrqEn = 1'b0;
    ackOn = 1'b0;
    ackWait = 4'h0;
    extIrqPin = 4'hf;
    pcInputPin = 27'h7ffffff;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    cyc(4);
    t_regs();
    t_ext();
    t_pc();
    stop_test();
  end
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule // tb_eapc_irq
bind eapc_irq eapc_irq_monitor i_eapc_irq_monitor (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .globalIrqEn(globalIrqEn),
  .irqReq(irqReq), .irqAck(irqAck), .extIrqPin(extIrqPin), .pcInputPin(pcInputPin));
